// *** pkg/sew_conv_if.sv ***
`timescale 1ns/1ps
interface sew_conv_if;
    logic start;
    logic [sew_pkg::CONV_W-1:0] sample;
    logic [sew_pkg::CONV_W-1:0] thresh;
    logic clk_req;
    logic done;
    logic match;
    logic [sew_pkg::CONV_W-1:0] result;

    modport ctrl (
        output start,
        output sample,
        output thresh,
        input clk_req,
        input done,
        input match,
        input result
    );

    modport conv (
        input start,
        input sample,
        input thresh,
        output clk_req,
        output done,
        output match,
        output result
    );
endinterface

// *** pkg/sew_pkg.sv ***
package sew_pkg;

    // ****************************************************************
    // clock and periodic trigger timing
    // ****************************************************************
    localparam int CLK_HZ = 40000000;
    localparam int RTC_PERIOD_MS = 10;
    localparam int RTC_PERIOD_CYC_DEF = (CLK_HZ / 1000) * RTC_PERIOD_MS;
    localparam int RTC_CNT_W = 19;

    // ****************************************************************
    // converter
    // ****************************************************************
    localparam int CONV_W = 12;
    localparam int CONV_CNT_W = 3;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = 3'h3;

    // ****************************************************************
    // event router size
    // ****************************************************************
    localparam int NUM_GEN = 2;
    localparam int NUM_USER = 2;
    localparam int GEN_RTC = 0;
    localparam int GEN_BUTTON = 1;
    localparam int USER_CONV = 0;
    localparam int USER_POWER_MANAGER = 1;

    // ****************************************************************
    // sleep mode codes from the core
    // ****************************************************************
    localparam logic [1:0] SLEEP_IDLE = 2'h0;
    localparam logic [1:0] SLEEP_STANDBY = 2'h1;
    localparam logic [1:0] SLEEP_HIBERNATE = 2'h2;
    localparam logic [1:0] SLEEP_OFF = 2'h3;

    // ****************************************************************
    // mode controller states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_STANDBY_INTERRUPT = 3'h1,
        ST_STANDBY_EVENT = 3'h2,
        ST_ACTIVE = 3'h4
    } sew_mode_e;

endpackage

// *** tb/sew_chk.sv ***
`timescale 1ns/1ps
module sew_chk #(
    parameter int RTC_PERIOD_CYC = 40
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [sew_pkg::CONV_W-1:0] low_thresh_i,
    input wire logic cpu_running_i,
    input wire logic [2:0] mode_o,
    input wire logic rtc_irq_o,
    input wire logic win_irq_o,
    input wire logic btn_irq_o,
    input wire logic wake_req_o,
    input wire logic sys_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic conv_clk_req_o,
    input wire logic sram_retain_o,
    input wire logic [sew_pkg::CONV_W-1:0] result_o
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_busy;
        conv_clk_req_o [*4] ##1 !conv_clk_req_o;
    endsequence
    sequence s_woken;
        wake_req_o && sys_clk_en_o && periph_clk_en_o;
    endsequence
    // cycle phase within the timer period, counted from reset release
    int ph;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ph <= 0;
        end else if (ph == RTC_PERIOD_CYC - 1) begin
            ph <= 0;
        end else begin
            ph <= ph + 1;
        end
    end
    a_timer_period: assert property (rtc_irq_o |-> ph == 0)
        else $error("timer interrupt off its period");
    a_reset_state: assert property ($fell(sys_rst_i) |-> mode_o == 3'h1 && sram_retain_o && !sys_clk_en_o)
        else $error("state after reset wrong");
    a_timer_wakes: assert property (rtc_irq_o |-> s_woken ##1 !rtc_irq_o)
        else $error("timer interrupt without wake");
    a_timer_mode: assert property (rtc_irq_o |-> $past(mode_o) == 3'h1)
        else $error("timer interrupt outside interrupt standby");
    a_conv_clock: assert property ($rose(conv_clk_req_o) |-> s_busy)
        else $error("converter clock request length wrong");
    a_window_cause: assert property (win_irq_o |-> $past(conv_clk_req_o, 2) && !$past(conv_clk_req_o)
        && result_o > low_thresh_i)
        else $error("window interrupt without match");
    a_match_active: assert property (win_irq_o |-> s_woken ##0 (mode_o == 3'h4 && !sram_retain_o))
        else $error("match did not wake");
    a_clock_pair: assert property (periph_clk_en_o == sys_clk_en_o)
        else $error("clock enables differ");
    a_retention: assert property (sram_retain_o == (mode_o != 3'h4 && !sys_clk_en_o))
        else $error("retention wrong");
    a_wake_hold: assert property (wake_req_o && !(cpu_running_i && sys_clk_en_o) |=> wake_req_o)
        else $error("wake dropped early");
    a_wake_clear: assert property (wake_req_o && cpu_running_i && sys_clk_en_o |=>
        !wake_req_o || rtc_irq_o || win_irq_o || btn_irq_o)
        else $error("wake not cleared");
    a_button_wake: assert property (btn_irq_o |-> s_woken ##0 mode_o != 3'h4)
        else $error("button interrupt wrong");
endmodule

// *** tb/sew_core_model.sv ***
`timescale 1ns/1ps
module sew_core_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] mode_i,
    input wire logic rtc_irq_i,
    input wire logic wake_req_i,
    input wire logic sys_clk_en_i,
    output logic cpu_running_o,
    output logic cpu_sleep_o,
    output logic cpu_start_conv_o
);
    // ****************************************
    // core: runs on clock, converts on timer, sleeps
    // ****************************************
    always @(negedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_running_o <= 1'b0;
            cpu_sleep_o <= 1'b0;
            cpu_start_conv_o <= 1'b0;
        end else begin
            cpu_running_o <= sys_clk_en_i;
            cpu_start_conv_o <= rtc_irq_i;
            cpu_sleep_o <= cpu_running_o && !wake_req_i && mode_i != 3'h4 && !rtc_irq_i && !cpu_start_conv_o;
        end
    end
endmodule

// *** tb/sew_top_tb.sv ***
`timescale 1ns/1ps
module sew_top_tb;
    localparam int P = 40;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic user_button_i = 1'b0;
    logic [sew_pkg::CONV_W-1:0] analog_value_i = 12'h123;
    logic [sew_pkg::CONV_W-1:0] low_thresh_i = 12'hFFF;
    logic [1:0] sleep_mode_i = 2'h1;
    logic cpu_running_i, cpu_sleep_i, cpu_start_conv_i;
    logic [2:0] mode_o;
    logic rtc_irq_o, win_irq_o, btn_irq_o, wake_req_o, sys_clk_en_o, periph_clk_en_o, conv_clk_req_o, sram_retain_o;
    logic [sew_pkg::CONV_W-1:0] result_o;
    logic conv_q = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_rtc = 0;
    int n_win = 0;
    int n_conv = 0;
    int b;
    int r;
    // ****************************************
    // clock, design, core, monitor
    // ****************************************
    always #12.5 clk_i = ~clk_i;
    sew_top #(.RTC_PERIOD_CYC(P)) sew_top_inst (.clk_i, .sys_rst_i, .user_button_i, .analog_value_i,
        .low_thresh_i, .sleep_mode_i, .cpu_running_i, .cpu_sleep_i, .cpu_start_conv_i, .mode_o, .rtc_irq_o,
        .win_irq_o, .btn_irq_o, .wake_req_o, .sys_clk_en_o, .periph_clk_en_o, .conv_clk_req_o, .sram_retain_o,
        .result_o);
    sew_core_model sew_core_model_inst (.clk_i, .sys_rst_i, .mode_i(mode_o), .rtc_irq_i(rtc_irq_o),
        .wake_req_i(wake_req_o), .sys_clk_en_i(sys_clk_en_o), .cpu_running_o(cpu_running_i),
        .cpu_sleep_o(cpu_sleep_i), .cpu_start_conv_o(cpu_start_conv_i));
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        conv_q <= conv_clk_req_o;
        if (rtc_irq_o === 1'b1) n_rtc = n_rtc + 1;
        if (win_irq_o === 1'b1) n_win = n_win + 1;
        if (conv_clk_req_o === 1'b1 && conv_q === 1'b0) n_conv = n_conv + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic press(input logic [2:0] m);
        user_button_i = 1'b1;
        idle(4);
        user_button_i = 1'b0;
        idle(4);
        chk(12'(mode_o), 12'(m));
    endtask
    task automatic wait_win();
        b = n_win;
        for (int i = 0; i < 2 * P && n_win == b; i++) idle(1);
        chk(12'(n_win - b), 12'h001);
        chk(12'(mode_o), 12'h004);
        chk(12'(sys_clk_en_o), 12'h001);
        chk(result_o, analog_value_i);
    endtask
    task automatic t_irq_mismatch();
        b = n_conv;
        r = n_rtc;
        idle(P + 2);
        chk(12'(n_rtc - r), 12'h001);
        chk(12'(n_conv - b), 12'h001);
        chk(12'(mode_o), 12'h001);
        chk(result_o, 12'h123);
        $display("irq mismatch done");
    endtask
    task automatic t_event_runs();
        press(3'h2);
        analog_value_i = 12'h7FF;
        low_thresh_i = 12'h7FF;
        sleep_mode_i = 2'h2;
        idle(2);
        b = n_conv;
        idle(2 * P);
        chk(12'(n_conv - b), 12'h000);
        sleep_mode_i = 2'h1;
        for (int i = 0; i < 20 && sys_clk_en_o !== 1'b0; i++) idle(1);
        b = n_conv;
        r = n_rtc;
        idle(P);
        chk(12'(n_conv - b), 12'h001);
        chk(12'(n_rtc - r), 12'h000);
        chk(12'(sys_clk_en_o), 12'h000);
        chk(12'(mode_o), 12'h002);
        $display("event runs done");
    endtask
    task automatic t_active();
        analog_value_i = 12'h800;
        wait_win();
        r = n_rtc;
        b = n_win;
        idle(2 * P);
        chk(12'(mode_o), 12'h004);
        chk(12'(n_rtc - r + n_win - b), 12'h000);
        analog_value_i = 12'h000;
        press(3'h2);
        press(3'h1);
        analog_value_i = 12'h900;
        wait_win();
        analog_value_i = 12'h000;
        press(3'h1);
        $display("active done");
    endtask
    initial begin
        idle(5);
        sys_rst_i = 1'b0;
        idle(1);
        chk(12'(mode_o), 12'h001);
        chk(12'(sram_retain_o), 12'h001);
        chk(12'(sys_clk_en_o), 12'h000);
        $display("reset done");
        t_irq_mismatch();
        t_event_runs();
        t_active();
        end_sim();
    end
endmodule
bind sew_top sew_chk #(.RTC_PERIOD_CYC(RTC_PERIOD_CYC)) sew_chk_inst (.clk_i, .sys_rst_i, .low_thresh_i,
    .cpu_running_i, .mode_o, .rtc_irq_o, .win_irq_o, .btn_irq_o, .wake_req_o, .sys_clk_en_o,
    .periph_clk_en_o, .conv_clk_req_o, .sram_retain_o, .result_o);

// *** verilog/sew_conv.sv ***
`timescale 1ns/1ps
module sew_conv (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    sew_conv_if.conv cif
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic busy;
        logic [sew_pkg::CONV_CNT_W-1:0] cnt;
        logic [sew_pkg::CONV_W-1:0] result;
        logic clk_req;
        logic done;
        logic match;
    } sew_conv_s;

    sew_conv_s s;
    sew_conv_s next_s;

    // ****************************************************************
    // conversion sequence
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.match = 1'b0;
        if (!s.busy) begin
            if (cif.start) begin
                next_s.busy = 1'b1;
                next_s.clk_req = 1'b1;
                next_s.cnt = '0;
                next_s.result = cif.sample;
            end
        end else if (s.cnt == sew_pkg::CONV_LAST) begin
            next_s.busy = 1'b0;
            next_s.clk_req = 1'b0;
            next_s.done = 1'b1;
            next_s.match = (s.result > cif.thresh);
        end else begin
            next_s.cnt = s.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cif.clk_req = s.clk_req;
    assign cif.done = s.done;
    assign cif.match = s.match;
    assign cif.result = s.result;

endmodule

// *** verilog/sew_top.sv ***
// Overview of operation
// - router joins the timer to the converter and the button to the power manager
// - events travel on dedicated wires, never over bus or memory
// - converter requests its own clock while the processor sleeps
// - on-demand converter clock leaves the system clock stopped
// - valid window match raises wake request enabling system and peripheral clocks
// - memory retention held during autonomous work until wake
// - autonomous conversions only in the standby sleep mode
// - reset enters interrupt-driven standby
// - button press in interrupt standby moves to event standby
// - interrupt standby: timer interrupt wakes processor every 10 ms
// - match gives window interrupt and active; mismatch returns to sleep
// - event standby: timer event every 10 ms starts conversion via router
// - event standby sleeps until window or button interrupt; window goes active
// - button press in event standby moves to interrupt standby
// - active persists until button press returns to a standby state
// - window matches when result exceeds the low threshold
`timescale 1ns/1ps
module sew_top #(
    parameter int RTC_PERIOD_CYC = sew_pkg::RTC_PERIOD_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic user_button_i,
    input wire logic [sew_pkg::CONV_W-1:0] analog_value_i,
    input wire logic [sew_pkg::CONV_W-1:0] low_thresh_i,
    input wire logic [1:0] sleep_mode_i,
    input wire logic cpu_running_i,
    input wire logic cpu_sleep_i,
    input wire logic cpu_start_conv_i,
    output logic [2:0] mode_o,
    output logic rtc_irq_o,
    output logic win_irq_o,
    output logic btn_irq_o,
    output logic wake_req_o,
    output logic sys_clk_en_o,
    output logic periph_clk_en_o,
    output logic conv_clk_req_o,
    output logic sram_retain_o,
    output logic [sew_pkg::CONV_W-1:0] result_o
);

    localparam logic [sew_pkg::RTC_CNT_W-1:0] RTC_LAST = sew_pkg::RTC_CNT_W'(RTC_PERIOD_CYC - 1);
    localparam logic [sew_pkg::RTC_CNT_W-1:0] RTC_STEP = 19'h00001;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        sew_pkg::sew_mode_e mode;
        logic prev_event;
        logic [sew_pkg::RTC_CNT_W-1:0] rtc_cnt;
        logic btn_s1;
        logic btn_s2;
        logic btn_d;
        logic [sew_pkg::CONV_W-1:0] val_s1;
        logic [sew_pkg::CONV_W-1:0] val_s2;
        logic rtc_irq;
        logic win_irq;
        logic btn_irq;
        logic wake;
        logic sys_clk;
        logic periph_clk;
        logic retain;
    } sew_top_s;

    sew_top_s s;
    sew_top_s next_s;

    sew_conv_if cif ();

    logic rtc_tick;
    logic btn_press;
    logic standby;
    logic auto_ok;
    logic cpu_start;
    logic wake_set;
    logic wake_clr;
    logic clk_set;
    logic clk_clr;
    logic [sew_pkg::NUM_GEN-1:0] gen_evt;
    logic [sew_pkg::NUM_GEN-1:0] route [sew_pkg::NUM_USER];
    logic [sew_pkg::NUM_USER-1:0] user_evt;

    // ****************************************************************
    // converter
    // ****************************************************************
    sew_conv u_conv (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .cif(cif)
    );

    // ****************************************************************
    // trigger sources
    // ****************************************************************
    assign rtc_tick = (s.rtc_cnt == RTC_LAST);
    assign btn_press = s.btn_s2 & ~s.btn_d;
    assign standby = (s.mode != sew_pkg::ST_ACTIVE);
    assign auto_ok = (s.mode == sew_pkg::ST_STANDBY_EVENT) &&
                     (sleep_mode_i == sew_pkg::SLEEP_STANDBY);

    assign gen_evt[sew_pkg::GEN_RTC] = rtc_tick;
    assign gen_evt[sew_pkg::GEN_BUTTON] = btn_press;

    // ****************************************************************
    // event router
    // ****************************************************************
    always_comb begin
        route[sew_pkg::USER_CONV] = '0;
        route[sew_pkg::USER_CONV][sew_pkg::GEN_RTC] = auto_ok;
        route[sew_pkg::USER_POWER_MANAGER] = '0;
        route[sew_pkg::USER_POWER_MANAGER][sew_pkg::GEN_BUTTON] = standby;
    end

    // each user ors every generator routed to it, fan-out is free
    for (genvar u = 0; u < sew_pkg::NUM_USER; u++) begin : g_user
        assign user_evt[u] = |(gen_evt & route[u]);
    end

    assign cpu_start = (s.mode == sew_pkg::ST_STANDBY_INTERRUPT) & cpu_start_conv_i & s.sys_clk;
    assign cif.start = user_evt[sew_pkg::USER_CONV] | cpu_start;
    assign cif.sample = s.val_s2;
    assign cif.thresh = low_thresh_i;

    // ****************************************************************
    // wake and clock control
    // ****************************************************************
    assign wake_set = (rtc_tick & (s.mode == sew_pkg::ST_STANDBY_INTERRUPT)) |
                      (cif.match & standby) |
                      user_evt[sew_pkg::USER_POWER_MANAGER];
    assign wake_clr = cpu_running_i & s.sys_clk;
    assign clk_set = wake_set;
    assign clk_clr = (cif.done & ~cif.match & (s.mode == sew_pkg::ST_STANDBY_INTERRUPT)) |
                     (cpu_sleep_i & standby & ~s.wake);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.btn_s1 = user_button_i;
        next_s.btn_s2 = s.btn_s1;
        next_s.btn_d = s.btn_s2;
        next_s.val_s1 = analog_value_i;
        next_s.val_s2 = s.val_s1;

        if (rtc_tick) begin
            next_s.rtc_cnt = '0;
        end else begin
            next_s.rtc_cnt = s.rtc_cnt + RTC_STEP;
        end

        next_s.rtc_irq = rtc_tick & (s.mode == sew_pkg::ST_STANDBY_INTERRUPT);
        next_s.win_irq = cif.match & standby;
        next_s.btn_irq = btn_press & standby;

        case (s.mode)
            sew_pkg::ST_STANDBY_INTERRUPT: begin
                if (cif.match) begin
                    next_s.mode = sew_pkg::ST_ACTIVE;
                    next_s.prev_event = 1'b0;
                end else if (btn_press) begin
                    next_s.mode = sew_pkg::ST_STANDBY_EVENT;
                end
            end
            sew_pkg::ST_STANDBY_EVENT: begin
                if (cif.match) begin
                    next_s.mode = sew_pkg::ST_ACTIVE;
                    next_s.prev_event = 1'b1;
                end else if (btn_press) begin
                    next_s.mode = sew_pkg::ST_STANDBY_INTERRUPT;
                end
            end
            sew_pkg::ST_ACTIVE: begin
                if (btn_press) begin
                    next_s.mode = s.prev_event ? sew_pkg::ST_STANDBY_EVENT :
                                                 sew_pkg::ST_STANDBY_INTERRUPT;
                end
            end
            default: begin
                next_s.mode = sew_pkg::ST_STANDBY_INTERRUPT;
            end
        endcase

        next_s.wake = wake_set | (s.wake & ~wake_clr);
        next_s.sys_clk = clk_set | (next_s.mode == sew_pkg::ST_ACTIVE) |
                         (s.sys_clk & ~clk_clr);
        next_s.periph_clk = next_s.sys_clk;
        next_s.retain = (next_s.mode != sew_pkg::ST_ACTIVE) & ~next_s.sys_clk;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= '0;
            s.mode <= sew_pkg::ST_STANDBY_INTERRUPT;
            s.retain <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mode_o = s.mode;
    assign rtc_irq_o = s.rtc_irq;
    assign win_irq_o = s.win_irq;
    assign btn_irq_o = s.btn_irq;
    assign wake_req_o = s.wake;
    assign sys_clk_en_o = s.sys_clk;
    assign periph_clk_en_o = s.periph_clk;
    assign conv_clk_req_o = cif.clk_req;
    assign sram_retain_o = s.retain;
    assign result_o = cif.result;

endmodule
